/* hw/mdcb_map.svh */
`ifndef MDCB_MAP_SVH
`define MDCB_MAP_SVH
`define MDCB_ADDR_WORD_A      8'h95
`define MDCB_ADDR_WORD_B      8'h96
`define MDCB_RESET_WORD       16'h0000
`define MDCB_WORD_B_WMASK     16'hFF7F
`define MDCB_A_SPEED_TYPE     15
`define MDCB_A_FREQ_SEL       14
`define MDCB_A_KT_HI          13
`define MDCB_A_KT_LO          12
`define MDCB_A_IND_GUARD      11
`define MDCB_A_MECH_GUARD     10
`define MDCB_A_MECH_TARGET    9
`define MDCB_A_RELEASE_STATE  8
`define MDCB_A_OPEN_LOOP      7
`define MDCB_A_RAMP_HI        6
`define MDCB_A_RAMP_LO        4
`define MDCB_A_DUTY_HI        3
`define MDCB_A_DUTY_LO        2
`define MDCB_A_EDGE_HI        1
`define MDCB_A_EDGE_LO        0
`define MDCB_B_LEAD_HI        15
`define MDCB_B_LEAD_LO        14
`define MDCB_B_CUR_HI         13
`define MDCB_B_CUR_LO         10
`define MDCB_B_RATE_HI        9
`define MDCB_B_RATE_LO        8
`define MDCB_B_GAIN_HI        6
`define MDCB_B_GAIN_LO        5
`define MDCB_B_GAP_HI         4
`define MDCB_B_GAP_LO         0
`define MDCB_FREQ_LOW_KHZ     25
`define MDCB_FREQ_HIGH_KHZ    50
`define MDCB_GAP_STEP_NS      40
`define MDCB_CLK_PERIOD_NS    50
`define MDCB_ZERO_WORD        16'h0000
`define MDCB_GAP_CYC_RESET    6'h01
`endif

/* hw/mdcb_pkg.sv */
package mdcb_pkg;
  typedef logic [7:0]  mdcb_addr_t;
  typedef logic [15:0] mdcb_word_t;
  typedef enum logic [1:0] {
    MDCB_SEL_NONE,
    MDCB_SEL_A,
    MDCB_SEL_B
  } mdcb_sel_t;
endpackage : mdcb_pkg

/* hw/mdcb_store_if.sv */
interface mdcb_store_if;
  logic               wr_en;
  logic               sel_b;
  mdcb_pkg::mdcb_word_t wr_data;
  mdcb_pkg::mdcb_word_t word_a;
  mdcb_pkg::mdcb_word_t word_b;
  modport ctrl (output wr_en, output sel_b, output wr_data, input word_a, input word_b);
  modport store (input wr_en, input sel_b, input wr_data, output word_a, output word_b);
endinterface : mdcb_store_if

/* hw/mdcb_store.sv */
`include "mdcb_map.svh"
module mdcb_store (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // access
  mdcb_store_if.store st
);
  import mdcb_pkg::*;
  mdcb_word_t word_a_r;
  mdcb_word_t word_a_nxt;
  mdcb_word_t word_b_r;
  mdcb_word_t word_b_nxt;

  always_comb begin
    word_a_nxt = word_a_r;
    word_b_nxt = word_b_r;
    if (st.wr_en && !st.sel_b) begin
      word_a_nxt = st.wr_data;
    end
    if (st.wr_en && st.sel_b) begin
      word_b_nxt = st.wr_data & `MDCB_WORD_B_WMASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      word_a_r <= `MDCB_RESET_WORD;
      word_b_r <= `MDCB_RESET_WORD;
    end else if (clk_en_in) begin
      word_a_r <= word_a_nxt;
      word_b_r <= word_b_nxt;
    end
  end

  assign st.word_a = word_a_r;
  assign st.word_b = word_b_r;
endmodule : mdcb_store

/* hw/mdcb_config_bank.sv */
// Overview of operation
// - word A bit 15 selects analog (0) or PWM (1) speed input.
// - word A bit 14 selects 25 kHz (0) or 50 kHz (1) drive frequency.
// - bits 13:12 choose torque-constant lock high/low window.
// - bit 11 enables inductive surge protection.
// - bit 10 enables mechanical surge protection.
// - bit 8 release state: brake (0) or high impedance (1).
// - bit 7 set keeps controller in open loop forever.
// - bits 3:2 set duty floor 5%/10% and below-1.5% output 0%/100%.
// - bits 1:0 select edge speed, slowest 00 to fastest 11.
// - word A at 0x95, sixteen bits read/write, resets zero.
// - word B at 0x96 holds lead, current, rate, gain, gap; bit 7 zero.
// - gap field gives (n+1) times 40 ns dead time.
// - current field 0000 disables sensing; otherwise 0.2 A times (n+1), 0001 is 0.4 A.
// - lead field gives 30, 60, 90 or 120 electrical degrees.
// - pulse rate field: 12 Hz at 00, doubling each step.
`include "mdcb_map.svh"
module mdcb_config_bank (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 clk_en_in,
  // register port
  input  wire mdcb_pkg::mdcb_addr_t reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire mdcb_pkg::mdcb_word_t reg_wdata_in,
  output logic [15:0]               reg_rdata_out,
  output logic                      reg_hit_out,
  // word A fields
  output logic                      speed_input_type_out,
  output logic                      drive_freq_select_out,
  output logic [7:0]                drive_freq_khz_out,
  output logic [1:0]                torque_const_lock_window_out,
  output logic                      inductive_surge_guard_on_out,
  output logic                      mechanical_surge_guard_on_out,
  output logic                      mechanical_surge_target_out,
  output logic                      position_sense_release_state_out,
  output logic                      stay_open_loop_out,
  output logic [2:0]                closed_loop_ramp_rate_out,
  output logic [1:0]                min_on_ratio_policy_out,
  output logic [1:0]                edge_speed_select_out,
  // word B fields
  output logic [1:0]                post_sense_lead_angle_out,
  output logic [3:0]                position_sense_current_level_out,
  output logic                      position_sense_enable_out,
  output logic [1:0]                position_sense_pulse_rate_out,
  output logic [1:0]                loop_gain_constant_out,
  output logic [4:0]                switch_gap_length_out,
  output logic [5:0]                switch_gap_cycles_out
);
  import mdcb_pkg::*;

  mdcb_store_if st ();
  mdcb_sel_t    sel;
  mdcb_word_t   rdata_r;
  mdcb_word_t   rdata_nxt;
  logic [5:0]   gap_cyc_r;
  logic [5:0]   gap_cyc_nxt;
  mdcb_word_t   word_a_view;
  mdcb_word_t   word_b_view;
  logic [7:0]   khz_r;
  logic [7:0]   khz_nxt;
  logic         sense_en_r;
  logic         sense_en_nxt;

  function automatic mdcb_sel_t decode(input mdcb_addr_t a);
    if (a == `MDCB_ADDR_WORD_A) begin
      decode = MDCB_SEL_A;
    end else if (a == `MDCB_ADDR_WORD_B) begin
      decode = MDCB_SEL_B;
    end else begin
      decode = MDCB_SEL_NONE;
    end
  endfunction : decode

  function automatic logic [7:0] khz_of(input logic fast);
    if (fast) begin
      khz_of = 8'(`MDCB_FREQ_HIGH_KHZ);
    end else begin
      khz_of = 8'(`MDCB_FREQ_LOW_KHZ);
    end
  endfunction : khz_of

  always_comb begin
    sel = decode(reg_addr_in);
  end

  assign reg_hit_out = (sel != MDCB_SEL_NONE);
  assign st.wr_en    = reg_wr_in && (sel != MDCB_SEL_NONE);
  assign st.sel_b    = (sel == MDCB_SEL_B);
  assign st.wr_data  = reg_wdata_in;

  mdcb_store u_store (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in (clk_en_in),
    .st        (st)
  );

  // read data registered; unmapped reads give zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_in) begin
      unique case (sel)
        MDCB_SEL_A: begin
          rdata_nxt = st.word_a;
        end
        MDCB_SEL_B: begin
          rdata_nxt = st.word_b & `MDCB_WORD_B_WMASK;
        end
        MDCB_SEL_NONE: begin
          rdata_nxt = `MDCB_ZERO_WORD;
        end
      endcase
    end
  end

  // dead time in 50 ns clock cycles, rounded up: ceil((n+1)*40/50)
  always_comb begin
    logic [10:0] ns;
    ns = 11'((st.word_b[`MDCB_B_GAP_HI:`MDCB_B_GAP_LO] + 6'd1) * `MDCB_GAP_STEP_NS);
    gap_cyc_nxt = 6'((ns + 11'(`MDCB_CLK_PERIOD_NS - 1)) / 11'(`MDCB_CLK_PERIOD_NS));
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_r   <= `MDCB_ZERO_WORD;
      gap_cyc_r <= `MDCB_GAP_CYC_RESET;
    end else if (clk_en_in) begin
      rdata_r   <= rdata_nxt;
      gap_cyc_r <= gap_cyc_nxt;
    end
  end

  // words as they stand after this edge, so the frequency and sense-enable flops stay in step with the store
  always_comb begin
    word_a_view = st.word_a;
    word_b_view = st.word_b;
    if (st.wr_en && !st.sel_b) begin
      word_a_view = st.wr_data;
    end
    if (st.wr_en && st.sel_b) begin
      word_b_view = st.wr_data & `MDCB_WORD_B_WMASK;
    end
  end

  always_comb begin
    khz_nxt      = khz_of(word_a_view[`MDCB_A_FREQ_SEL]);
    sense_en_nxt = |word_b_view[`MDCB_B_CUR_HI:`MDCB_B_CUR_LO];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      khz_r      <= 8'(`MDCB_FREQ_LOW_KHZ);
      sense_en_r <= 1'h0;
    end else if (clk_en_in) begin
      khz_r      <= khz_nxt;
      sense_en_r <= sense_en_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  assign speed_input_type_out             = st.word_a[`MDCB_A_SPEED_TYPE];
  assign drive_freq_select_out            = st.word_a[`MDCB_A_FREQ_SEL];
  assign drive_freq_khz_out               = khz_r;
  assign torque_const_lock_window_out     = st.word_a[`MDCB_A_KT_HI:`MDCB_A_KT_LO];
  assign inductive_surge_guard_on_out     = st.word_a[`MDCB_A_IND_GUARD];
  assign mechanical_surge_guard_on_out    = st.word_a[`MDCB_A_MECH_GUARD];
  assign mechanical_surge_target_out      = st.word_a[`MDCB_A_MECH_TARGET];
  assign position_sense_release_state_out = st.word_a[`MDCB_A_RELEASE_STATE];
  assign stay_open_loop_out               = st.word_a[`MDCB_A_OPEN_LOOP];
  assign closed_loop_ramp_rate_out        = st.word_a[`MDCB_A_RAMP_HI:`MDCB_A_RAMP_LO];
  assign min_on_ratio_policy_out          = st.word_a[`MDCB_A_DUTY_HI:`MDCB_A_DUTY_LO];
  assign edge_speed_select_out            = st.word_a[`MDCB_A_EDGE_HI:`MDCB_A_EDGE_LO];

  assign post_sense_lead_angle_out        = st.word_b[`MDCB_B_LEAD_HI:`MDCB_B_LEAD_LO];
  assign position_sense_current_level_out = st.word_b[`MDCB_B_CUR_HI:`MDCB_B_CUR_LO];
  assign position_sense_enable_out        = sense_en_r;
  assign position_sense_pulse_rate_out    = st.word_b[`MDCB_B_RATE_HI:`MDCB_B_RATE_LO];
  assign loop_gain_constant_out           = st.word_b[`MDCB_B_GAIN_HI:`MDCB_B_GAIN_LO];
  assign switch_gap_length_out            = st.word_b[`MDCB_B_GAP_HI:`MDCB_B_GAP_LO];
  assign switch_gap_cycles_out            = gap_cyc_r;
endmodule : mdcb_config_bank

/* verification/mdcb_config_bank_checker.sv */
module mdcb_config_bank_checker (
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 sys_rst_in,
  input wire logic                 clk_en_in,
  // register port
  input wire mdcb_pkg::mdcb_addr_t reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire mdcb_pkg::mdcb_word_t reg_wdata_in,
  input wire logic [15:0]          reg_rdata_out,
  // fields
  input wire logic                 speed_input_type_out,
  input wire logic                 drive_freq_select_out,
  input wire logic [7:0]           drive_freq_khz_out,
  input wire logic [1:0]           torque_const_lock_window_out,
  input wire logic [1:0]           min_on_ratio_policy_out,
  input wire logic [1:0]           edge_speed_select_out,
  input wire logic [3:0]           position_sense_current_level_out,
  input wire logic                 position_sense_enable_out,
  input wire logic [4:0]           switch_gap_length_out,
  input wire logic [5:0]           switch_gap_cycles_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import mdcb_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_wr_a; clk_en_in && reg_wr_in && reg_addr_in == 8'h95; endsequence
  sequence s_rd_miss; clk_en_in && reg_rd_in && reg_addr_in != 8'h95 && reg_addr_in != 8'h96; endsequence
  property p_spd; s_wr_a |=> speed_input_type_out == $past(reg_wdata_in[15]); endproperty
  a_spd: assert property (p_spd) else $error("speed type not taken from write");
  property p_freq; drive_freq_khz_out == (drive_freq_select_out ? 8'h32 : 8'h19); endproperty
  a_freq: assert property (p_freq) else $error("drive frequency decode wrong");
  property p_kt; s_wr_a |=> torque_const_lock_window_out == $past(reg_wdata_in[13:12]); endproperty
  a_kt: assert property (p_kt) else $error("lock window not taken from write");
  property p_low; s_wr_a |=> {min_on_ratio_policy_out, edge_speed_select_out} == $past(reg_wdata_in[3:0]); endproperty
  a_low: assert property (p_low) else $error("duty or edge field wrong");
  property p_sense; position_sense_enable_out == (position_sense_current_level_out != 4'h0); endproperty
  a_sense: assert property (p_sense) else $error("sense enable wrong");
  property p_gap;
    $past(clk_en_in) |->
      switch_gap_cycles_out == 6'((({7'h00, $past(switch_gap_length_out)} + 12'h001) * 12'h028 + 12'h031) / 12'h032);
  endproperty
  a_gap: assert property (p_gap) else $error("dead time cycles wrong");
  property p_hold; !(clk_en_in && reg_rd_in) |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_miss; s_rd_miss |=> reg_rdata_out == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
endmodule : mdcb_config_bank_checker

bind mdcb_config_bank mdcb_config_bank_checker i_chk (.*);

/* verification/tb_motor_drive_config_bank.sv */
module tb_motor_drive_config_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import mdcb_pkg::*;
  logic       clk_in = 0, sys_rst_in = 1, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  mdcb_addr_t reg_addr_in = 8'h00, a;
  mdcb_word_t reg_wdata_in = 16'h0000, a_m = 16'h0000, b_m = 16'h0000, rexp, fa, fb;
  logic [15:0] reg_rdata_out;
  logic       reg_hit_out, speed_input_type_out, drive_freq_select_out, inductive_surge_guard_on_out;
  logic       mechanical_surge_guard_on_out, mechanical_surge_target_out, position_sense_release_state_out;
  logic       stay_open_loop_out, position_sense_enable_out;
  logic [7:0] drive_freq_khz_out;
  logic [1:0] torque_const_lock_window_out, min_on_ratio_policy_out, edge_speed_select_out;
  logic [1:0] post_sense_lead_angle_out, position_sense_pulse_rate_out, loop_gain_constant_out;
  logic [2:0] closed_loop_ramp_rate_out;
  logic [3:0] position_sense_current_level_out;
  logic [4:0] switch_gap_length_out;
  logic [5:0] switch_gap_cycles_out;
  int         miscompares = 0, checked = 0;
  mdcb_config_bank i_dut (.*);
  always #25 clk_in = ~clk_in;
  task end_of_test;
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input mdcb_word_t seen, input mdcb_word_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // dead time (n+1)*40 ns in 50 ns cycles, rounded up
  function automatic mdcb_word_t exp_gap(input logic [4:0] n);
    logic [31:0] ns;
    ns = (32'(n) + 32'h1) * 32'h28;
    exp_gap = 16'((ns + 32'h31) / 32'h32);
  endfunction : exp_gap
  function automatic mdcb_word_t exp_khz(input logic fast);
    exp_khz = fast ? 16'h0032 : 16'h0019;
  endfunction : exp_khz
  // one cycle access, model follows only taken writes
  task op(input logic w, input logic r, input logic e, input mdcb_addr_t ad, input mdcb_word_t dt);
    @(posedge clk_in);
    #5;
    {reg_wr_in, reg_rd_in, clk_en_in, reg_addr_in, reg_wdata_in} = {w, r, e, ad, dt};
    @(posedge clk_in);
    #5;
    {reg_wr_in, reg_rd_in, clk_en_in} = 3'b001;
    if (e && w && ad == 8'h95) a_m = dt;
    if (e && w && ad == 8'h96) b_m = dt & 16'hFF7F;
  endtask : op
  task fchk;
    fa = {speed_input_type_out, drive_freq_select_out, torque_const_lock_window_out, inductive_surge_guard_on_out,
      mechanical_surge_guard_on_out, mechanical_surge_target_out, position_sense_release_state_out,
      stay_open_loop_out, closed_loop_ramp_rate_out, min_on_ratio_policy_out, edge_speed_select_out};
    fb = {post_sense_lead_angle_out, position_sense_current_level_out, position_sense_pulse_rate_out, 1'h0,
      loop_gain_constant_out, switch_gap_length_out};
    chk(fa, a_m);
    chk(fb, b_m);
    chk({8'h00, drive_freq_khz_out}, exp_khz(a_m[14]));
    chk({15'h0000, position_sense_enable_out}, {15'h0000, b_m[13:10] != 4'h0});
    @(posedge clk_in);
    #5;
    chk({10'h000, switch_gap_cycles_out}, exp_gap(b_m[4:0]));
  endtask : fchk
  initial begin
    void'($urandom(32'hf4ed));
    repeat (10) @(posedge clk_in);
    #5;
    sys_rst_in = 0;
    fchk;
    chk(reg_rdata_out, 16'h0000);
    op(1, 0, 1, 8'h95, 16'hFFFF);
    op(1, 0, 1, 8'h96, 16'hFFFF);
    fchk;
    op(0, 1, 1, 8'h96, 16'h0000);
    chk(reg_rdata_out, 16'hFF7F);
    op(1, 0, 0, 8'h96, 16'h0000);
    fchk;
    rexp = a_m;
    op(1, 1, 1, 8'h95, 16'h4A5C);
    chk(reg_rdata_out, rexp);
    for (int i = 0; i < 60; i++) begin
      a = ($urandom % 3 == 0) ? 8'($urandom) : 8'h95 + 8'($urandom % 2);
      op(1, 0, 1, a, 16'($urandom));
      chk({15'h0000, reg_hit_out}, {15'h0000, a == 8'h95 || a == 8'h96});
      fchk;
      rexp = (a == 8'h95) ? a_m : (a == 8'h96) ? b_m : 16'h0000;
      op(0, 1, 1, a, 16'h0000);
      chk(reg_rdata_out, rexp);
    end
    // mid-run reset with enable low: reset must still win
    op(1, 0, 1, 8'h96, 16'hABCD);
    @(posedge clk_in);
    #5;
    {sys_rst_in, clk_en_in} = 2'b10;
    repeat (2) @(posedge clk_in);
    #5;
    {sys_rst_in, clk_en_in} = 2'b01;
    a_m = 16'h0000;
    b_m = 16'h0000;
    fchk;
    chk(reg_rdata_out, 16'h0000);
    end_of_test;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule : tb_motor_drive_config_bank
